// ==== hw/ir_readout_pkg.sv ====
// Package: constants and signal carriers of the IR presence sensor readout
`default_nettype none
package ir_readout_pkg;
	// ================================================================
	// Timing
	localparam int unsigned CLK_HZ           = 200_000_000;
	localparam int unsigned RATE_BASE_HZ     = 120;
	localparam int unsigned BASE_TICK_CYCLES = CLK_HZ / RATE_BASE_HZ;
	// Base ticks per output period, one per output rate
	localparam logic [8:0] TICKS_0P25HZ = 9'h1e0;
	localparam logic [8:0] TICKS_0P5HZ  = 9'h0f0;
	localparam logic [8:0] TICKS_1HZ    = 9'h078;
	localparam logic [8:0] TICKS_2HZ    = 9'h03c;
	localparam logic [8:0] TICKS_4HZ    = 9'h01e;
	localparam logic [8:0] TICKS_8HZ    = 9'h00f;
	localparam logic [8:0] TICKS_15HZ   = 9'h008;
	localparam logic [8:0] TICKS_30HZ   = 9'h004;
	localparam logic [3:0] RATE_OFF     = 4'h0;
	// ================================================================
	// Scaling and compensation
	localparam int AMB_LSB_PER_C = 100;
	localparam int OBJ_LSB_PER_C = 2000;
	localparam int COMP_GAIN     = OBJ_LSB_PER_C / AMB_LSB_PER_C;
	localparam logic signed [15:0] AMB_REF = 16'(25 * AMB_LSB_PER_C);
	// ================================================================
	// Serial link
	localparam logic [7:0] SPI_READ_CMD     = 8'h80;
	localparam logic [6:0] I2C_ADDR_DEFAULT = 7'h2a;
	localparam int         FIFO_DEPTH       = 16;
	localparam int         SAMPLE_W         = 32;
	// ================================================================
	// Carriers
	typedef struct packed {
		logic              valid;
		logic signed [15:0] obj;
		logic signed [15:0] amb;
	} adc_result_t;
	typedef struct packed {
		logic signed [15:0] obj;
		logic signed [15:0] amb;
	} sample_t;
	typedef struct packed {
		logic motion_en;
		logic presence_en;
		logic overtemp_en;
	} detect_cfg_t;
	typedef struct packed {
		logic motion;
		logic presence;
		logic stationary;
		logic overtemp;
	} flags_t;
endpackage
`default_nettype wire

// ==== hw/ir_presence_sensor_readout.sv ====
// Design: sample FIFO and digital readout of the IR presence sensor
`default_nettype none

// ================================================================
// Sample FIFO
module sample_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 16
) (
	input  wire logic             i_core_clk,  // Core clock
	input  wire logic             i_reset_n,   // Async reset, active low
	input  wire logic             i_in_valid,  // Write request
	output logic                  o_in_ready,  // Space left
	input  wire logic [WIDTH-1:0] i_in_data,   // Write data
	output logic                  o_out_valid, // Data available
	input  wire logic             i_out_ready, // Read accept
	output logic [WIDTH-1:0]      o_out_data   // Head word
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr, rd, next_wr, next_rd;
	logic [AW:0]      cnt, next_cnt;
	logic             push, pop;

	// Pointers wrap naturally, so DEPTH must be a power of two
	always_comb begin
		push     = i_in_valid && o_in_ready;
		pop      = o_out_valid && i_out_ready;
		next_wr  = push ? AW'(wr + 1'b1) : wr;
		next_rd  = pop ? AW'(rd + 1'b1) : rd;
		next_cnt = cnt + (AW+1)'(push) - (AW+1)'(pop);
	end
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			wr  <= '0;
			rd  <= '0;
			cnt <= '0;
		end else begin
			wr  <= next_wr;
			rd  <= next_rd;
			cnt <= next_cnt;
		end
	end
	always_ff @(posedge i_core_clk) begin
		if (push) begin
			mem[wr] <= i_in_data;
		end
	end
	assign o_in_ready  = cnt != (AW+1)'(DEPTH);
	assign o_out_valid = cnt != '0;
	assign o_out_data  = mem[rd];
endmodule // sample_fifo

// ================================================================
// Readout top
module ir_presence_sensor_readout #(
	parameter int unsigned BASE_TICK  = ir_readout_pkg::BASE_TICK_CYCLES, // Cycles per 1/120 s
	parameter logic [6:0]  I2C_ADDR   = ir_readout_pkg::I2C_ADDR_DEFAULT,
	parameter int          COMP_SHIFT = 4,
	parameter int          FIFO_DEPTH = ir_readout_pkg::FIFO_DEPTH
) (
	input  wire logic                        i_core_clk,            // Core clock
	input  wire logic                        i_reset_n,             // Async reset, active low
	input  wire logic [3:0]                  i_output_rate_code,    // Output rate code
	input  wire logic                        i_one_shot,            // One-shot request pulse
	input  wire ir_readout_pkg::detect_cfg_t i_detect_cfg,          // Detection enables
	input  wire logic signed [15:0]          i_motion_thr,          // Motion delta threshold
	input  wire logic signed [15:0]          i_presence_thr,        // Presence threshold
	input  wire logic signed [15:0]          i_overtemp_thr,        // Overtemperature threshold
	input  wire ir_readout_pkg::adc_result_t i_adc,                 // Raw conversion result
	output logic                             o_acq_start,           // Start conversion pulse
	output logic                             o_power_down,          // Standby indication
	output ir_readout_pkg::flags_t           o_flags,               // Detection flags
	output logic                             o_int_pin,             // Interrupt, active high
	input  wire logic                        i_if_select_pin,       // Bus select / SPI select
	input  wire logic                        i_serial_clock_pin,    // Serial clock
	input  wire logic                        i_serial_data_io_pin,  // Data pin level
	output logic                             o_serial_data_io_pin,  // Data pin drive value
	output logic                             o_serial_data_io_oe_n  // Data pin enable, low drives
);
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_reset_n);

	typedef enum logic {ACQ_IDLE, ACQ_WAIT} acq_state_t;
	typedef enum logic [2:0] {SER_IDLE, SER_CMD, SER_ACK, SER_SEND, SER_HACK, SER_DONE} ser_state_t;

	function automatic logic [8:0] rate_ticks(input logic [3:0] code);
		unique casez (code)
			4'b1???: rate_ticks = ir_readout_pkg::TICKS_30HZ;
			4'h7:    rate_ticks = ir_readout_pkg::TICKS_15HZ;
			4'h6:    rate_ticks = ir_readout_pkg::TICKS_8HZ;
			4'h5:    rate_ticks = ir_readout_pkg::TICKS_4HZ;
			4'h4:    rate_ticks = ir_readout_pkg::TICKS_2HZ;
			4'h3:    rate_ticks = ir_readout_pkg::TICKS_1HZ;
			4'h2:    rate_ticks = ir_readout_pkg::TICKS_0P5HZ;
			default: rate_ticks = ir_readout_pkg::TICKS_0P25HZ;
		endcase
	endfunction

	// ================================================================
	// Rate timer and acquisition
	acq_state_t              acq_state, next_acq_state;
	logic [31:0]             tick_cnt, next_tick_cnt;
	logic [8:0]              per_cnt, next_per_cnt;
	logic                    acq_due, next_acq_due, one_pend, next_one_pend, due_set, start;
	logic                    next_acq_start, next_power_down, next_int;
	logic                    fifo_in_valid, next_fifo_in_valid, fifo_in_ready;
	ir_readout_pkg::sample_t fifo_in_data, next_fifo_in_data;
	ir_readout_pkg::flags_t  next_flags;
	logic signed [15:0]      prev_obj, next_prev_obj, obj_comp;
	logic signed [31:0]      drift, comp_wide, delta;
	logic                    moving, present;

	always_comb begin
		next_tick_cnt   = tick_cnt;
		next_per_cnt    = per_cnt;
		due_set         = 1'b0;
		next_power_down = i_output_rate_code == ir_readout_pkg::RATE_OFF;
		if (next_power_down) begin
			next_tick_cnt = '0;
			next_per_cnt  = '0;
		end else if (tick_cnt >= BASE_TICK - 1) begin
			next_tick_cnt = '0;
			if (per_cnt + 9'h001 >= rate_ticks(i_output_rate_code)) begin
				next_per_cnt = '0;
				due_set      = 1'b1;
			end else begin
				next_per_cnt = per_cnt + 9'h001;
			end
		end else begin
			next_tick_cnt = tick_cnt + 32'h1;
		end
		// A push still in flight may take the last slot
		start          = acq_state == ACQ_IDLE && (acq_due || one_pend) && fifo_in_ready && !fifo_in_valid;
		// A periodic request left over from before power-down must not convert later
		next_acq_due   = ((acq_due && !start) || due_set) && !next_power_down;
		next_one_pend  = (one_pend && !start) || i_one_shot;
		next_acq_start = start;
		next_acq_state = start ? ACQ_WAIT : acq_state;

		drift     = 32'(i_adc.amb) - 32'(ir_readout_pkg::AMB_REF);
		comp_wide = 32'(i_adc.obj) - ((drift * ir_readout_pkg::COMP_GAIN) >>> COMP_SHIFT);
		obj_comp  = comp_wide[15:0];
		delta     = 32'(obj_comp) - 32'(prev_obj);
		moving    = (delta < 0 ? -delta : delta) > 32'(i_motion_thr);
		present   = obj_comp > i_presence_thr;

		next_fifo_in_valid = 1'b0;
		next_fifo_in_data  = fifo_in_data;
		next_prev_obj      = prev_obj;
		next_flags.motion     = o_flags.motion && i_detect_cfg.motion_en;
		next_flags.presence   = o_flags.presence && i_detect_cfg.presence_en;
		next_flags.stationary = o_flags.stationary && i_detect_cfg.presence_en;
		next_flags.overtemp   = o_flags.overtemp && i_detect_cfg.overtemp_en;
		if (acq_state == ACQ_WAIT && i_adc.valid) begin
			next_acq_state     = ACQ_IDLE;
			next_fifo_in_valid = 1'b1;
			next_fifo_in_data  = '{obj: obj_comp, amb: i_adc.amb};
			next_prev_obj      = obj_comp;
			next_flags.motion     = moving && i_detect_cfg.motion_en;
			next_flags.presence   = present && i_detect_cfg.presence_en;
			next_flags.stationary = present && !moving && i_detect_cfg.presence_en;
			next_flags.overtemp   = obj_comp > i_overtemp_thr && i_detect_cfg.overtemp_en;
		end
		next_int = |next_flags;
	end

	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			acq_state     <= ACQ_IDLE;
			tick_cnt      <= '0;
			per_cnt       <= '0;
			acq_due       <= 1'b0;
			one_pend      <= 1'b0;
			o_acq_start   <= 1'b0;
			o_power_down  <= 1'b1;
			fifo_in_valid <= 1'b0;
			fifo_in_data  <= '0;
			prev_obj      <= '0;
			o_flags       <= '0;
			o_int_pin     <= 1'b0;
		end else begin
			acq_state     <= next_acq_state;
			tick_cnt      <= next_tick_cnt;
			per_cnt       <= next_per_cnt;
			acq_due       <= next_acq_due;
			one_pend      <= next_one_pend;
			o_acq_start   <= next_acq_start;
			o_power_down  <= next_power_down;
			fifo_in_valid <= next_fifo_in_valid;
			fifo_in_data  <= next_fifo_in_data;
			prev_obj      <= next_prev_obj;
			o_flags       <= next_flags;
			o_int_pin     <= next_int;
		end
	end

	// ================================================================
	// Sample buffer
	logic                          fifo_out_valid, fifo_pop;
	logic [ir_readout_pkg::SAMPLE_W-1:0] fifo_out_data, word;

	sample_fifo #(.WIDTH(ir_readout_pkg::SAMPLE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.i_core_clk  (i_core_clk),
		.i_reset_n   (i_reset_n),
		.i_in_valid  (fifo_in_valid),
		.o_in_ready  (fifo_in_ready),
		.i_in_data   (fifo_in_data),
		.o_out_valid (fifo_out_valid),
		.i_out_ready (fifo_pop),
		.o_out_data  (fifo_out_data)
	);

	// ================================================================
	// Serial readout, I2C or 3-wire SPI
	ser_state_t  ser_state, next_ser_state;
	logic [31:0] shreg, next_shreg;
	logic [3:0]  bcnt, next_bcnt;
	logic [1:0]  byte_cnt, next_byte_cnt;
	logic [7:0]  cmd;
	logic        rw, next_rw, scl_q, sda_q, cs_q, i2c, rise, fall, start_c, stop_c;
	logic        next_sdo, next_oe_n;

	always_comb begin
		next_ser_state = ser_state;
		next_shreg     = shreg;
		next_bcnt      = bcnt;
		next_byte_cnt  = byte_cnt;
		next_rw        = rw;
		next_sdo       = o_serial_data_io_pin;
		next_oe_n      = o_serial_data_io_oe_n;
		fifo_pop       = 1'b0;
		i2c     = i_if_select_pin;
		rise    = i_serial_clock_pin && !scl_q;
		fall    = !i_serial_clock_pin && scl_q;
		start_c = i2c && cs_q && i_serial_clock_pin && scl_q && sda_q && !i_serial_data_io_pin;
		stop_c  = i2c && cs_q && i_serial_clock_pin && scl_q && !sda_q && i_serial_data_io_pin;
		cmd     = {shreg[6:0], i_serial_data_io_pin};
		// An empty buffer reads as zero
		word    = fifo_out_valid ? fifo_out_data : '0;
		if (i2c != cs_q) begin
			next_ser_state = i2c ? SER_IDLE : SER_CMD;
			next_bcnt      = '0;
			next_oe_n      = 1'b1;
		end else if (start_c) begin
			next_ser_state = SER_CMD;
			next_bcnt      = '0;
			next_oe_n      = 1'b1;
		end else if (stop_c) begin
			next_ser_state = SER_IDLE;
			next_oe_n      = 1'b1;
		end else begin
			unique case (ser_state)
				SER_IDLE: begin
					next_oe_n = 1'b1;
				end
				SER_DONE: begin
					if (fall) begin
						next_oe_n = 1'b1;
					end
				end
				SER_CMD: begin
					if (rise) begin
						next_shreg = {shreg[30:0], i_serial_data_io_pin};
						next_bcnt  = bcnt + 4'h1;
						if (bcnt == 4'h7) begin
							if (!i2c && cmd == ir_readout_pkg::SPI_READ_CMD) begin
								next_shreg     = word;
								fifo_pop       = fifo_out_valid;
								next_ser_state = SER_SEND;
								next_bcnt      = '0;
								next_byte_cnt  = '0;
							end else if (i2c && cmd[7:1] == I2C_ADDR) begin
								next_rw        = cmd[0];
								next_ser_state = SER_ACK;
							end else begin
								next_ser_state = SER_DONE;
							end
						end
					end
				end
				SER_ACK: begin
					if (fall) begin
						next_sdo       = 1'b0;
						next_oe_n      = 1'b0;
						next_ser_state = rw ? SER_SEND : SER_DONE;
						next_bcnt      = '0;
						next_byte_cnt  = '0;
						if (rw) begin
							next_shreg = word;
							fifo_pop   = fifo_out_valid;
						end
					end
				end
				SER_SEND: begin
					if (fall) begin
						if (bcnt == 4'h8) begin
							next_oe_n      = 1'b1;
							next_ser_state = SER_HACK;
						end else begin
							// I2C only pulls low; SPI drives both levels
							next_sdo   = i2c ? 1'b0 : shreg[31];
							next_oe_n  = i2c ? shreg[31] : 1'b0;
							next_bcnt  = bcnt == 4'h7 ? (i2c ? 4'h8 : 4'h0) : bcnt + 4'h1;
							next_shreg = {shreg[30:0], 1'b0};
							if (bcnt == 4'h7) begin
								next_byte_cnt = byte_cnt + 2'h1;
								if (byte_cnt == 2'h3) begin
									next_shreg = word;
									fifo_pop   = fifo_out_valid;
								end
							end
						end
					end
				end
				SER_HACK: begin
					if (rise) begin
						next_ser_state = i_serial_data_io_pin ? SER_DONE : SER_SEND;
						next_bcnt      = '0;
					end
				end
			endcase
		end
	end

	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ser_state             <= SER_IDLE;
			shreg                 <= '0;
			bcnt                  <= '0;
			byte_cnt              <= '0;
			rw                    <= 1'b0;
			scl_q                 <= 1'b1;
			sda_q                 <= 1'b1;
			cs_q                  <= 1'b1;
			o_serial_data_io_pin  <= 1'b0;
			o_serial_data_io_oe_n <= 1'b1;
		end else begin
			ser_state             <= next_ser_state;
			shreg                 <= next_shreg;
			bcnt                  <= next_bcnt;
			byte_cnt              <= next_byte_cnt;
			rw                    <= next_rw;
			scl_q                 <= i_serial_clock_pin;
			sda_q                 <= i_serial_data_io_pin;
			cs_q                  <= i_if_select_pin;
			o_serial_data_io_pin  <= next_sdo;
			o_serial_data_io_oe_n <= next_oe_n;
		end
	end

	// ================================================================
	// Assertions
	a_sel_release: assert property ((i_if_select_pin != cs_q) |=> o_serial_data_io_oe_n)
		else $error("data pin still driven after bus select change");
	a_i2c_open_drain: assert property ((cs_q && !o_serial_data_io_oe_n) |-> !o_serial_data_io_pin)
		else $error("I2C drove data pin high");
	a_spi_drives: assert property ((!i2c && !cs_q && ser_state == SER_SEND && fall) |=> !o_serial_data_io_oe_n)
		else $error("SPI read did not drive data pin");
	a_rate_fastest: assert property (i_output_rate_code[3] |-> rate_ticks(i_output_rate_code) == 9'h004)
		else $error("top rate code not 30 Hz");
	a_sample_push: assert property ((acq_state == ACQ_WAIT && i_adc.valid) |=>
		fifo_in_valid && fifo_in_ready && fifo_in_data.amb == $past(i_adc.amb))
		else $error("sample not pushed with its ambient word");
	a_one_shot_start: assert property ((i_one_shot && acq_state == ACQ_IDLE && !one_pend && !acq_due
		&& !fifo_in_valid && fifo_in_ready) |-> ##2 o_acq_start)
		else $error("one-shot did not start acquisition");
	a_detect_gate: assert property (!i_detect_cfg.motion_en |=> !o_flags.motion)
		else $error("motion flag while disabled");
	a_int_matches: assert property (o_int_pin == (|o_flags))
		else $error("interrupt pin disagrees with flags");
	a_comp_neutral: assert property ((acq_state == ACQ_WAIT && i_adc.valid && i_adc.amb == ir_readout_pkg::AMB_REF)
		|=> fifo_in_data.obj == $past(i_adc.obj))
		else $error("object changed at reference ambient");
	a_power_down_idle: assert property ((i_output_rate_code == ir_readout_pkg::RATE_OFF) |=> !acq_due)
		else $error("conversion scheduled in power-down");

	c_one_shot: cover property (o_power_down && o_acq_start);
	c_i2c_ack: cover property (ser_state == SER_HACK && rise && !i_serial_data_io_pin);
	c_spi_read: cover property (ser_state == SER_SEND && !i2c && byte_cnt == 2'h3);
	c_stationary: cover property (o_flags.stationary);
endmodule // ir_presence_sensor_readout
`default_nettype wire

// ==== bench/host_serial_model.sv ====
// Host model: serial master doing 3-wire SPI and I2C reads
`default_nettype none
module host_serial_model (
	input  wire logic i_core_clk, // Core clock
	input  wire logic i_dev_pin,  // Device drive value
	input  wire logic i_dev_oe_n, // Device enable, low drives
	output logic      o_select,   // Bus select, low also selects SPI
	output logic      o_scl,      // Serial clock
	output logic      o_sda       // Resolved data wire
);
	timeunit 1ns;
	timeprecision 1ps;
	logic host_oe = 1'b0;
	logic host_val = 1'b0;
	logic i2c_low = 1'b0;
	logic last = 1'b0;
	initial o_select = 1'b1;
	initial o_scl = 1'b1;
	// ================================================================
	// Wire: I2C has a pull-up, an undriven SPI wire toggles
	always_comb begin
		if (o_select)
			o_sda = !i2c_low && (i_dev_oe_n || i_dev_pin);
		else if (host_oe)
			o_sda = host_val;
		else if (!i_dev_oe_n)
			o_sda = i_dev_pin;
		else
			o_sda = !last;
	end
	always @(posedge i_core_clk) last <= o_sda;
	task automatic half();
		repeat (4) @(negedge i_core_clk);
	endtask
	// ================================================================
	// SPI read of whole words in one select session
	task automatic spi_read(input int words, output logic [31:0] q[$]);
		logic [31:0] w;
		o_scl = 1'b0;
		half();
		o_select = 1'b0;
		host_oe = 1'b1;
		for (int i = 7; i >= 0; i--) begin
			host_val = ir_readout_pkg::SPI_READ_CMD[i];
			half();
			o_scl = 1'b1;
			half();
			o_scl = 1'b0;
		end
		host_oe = 1'b0;
		q = {};
		for (int k = 0; k < words; k++) begin
			for (int i = 31; i >= 0; i--) begin
				half();
				w[i] = o_sda;
				o_scl = 1'b1;
				half();
				o_scl = 1'b0;
			end
			q.push_back(w);
		end
		half();
		o_select = 1'b1;
		half();
		o_scl = 1'b1;
		half();
	endtask
	// ================================================================
	// I2C read of one byte, then nack and stop
	task automatic i2c_read(output logic ack, output logic [7:0] b);
		logic [7:0] a;
		a = {ir_readout_pkg::I2C_ADDR_DEFAULT, 1'b1};
		i2c_low = 1'b1;
		half();
		o_scl = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			i2c_low = !a[i];
			half();
			o_scl = 1'b1;
			half();
			o_scl = 1'b0;
		end
		i2c_low = 1'b0;
		for (int i = 8; i >= 0; i--) begin
			half();
			if (i == 8)
				ack = o_sda;
			else
				b = {b[6:0], o_sda};
			o_scl = 1'b1;
			half();
			o_scl = 1'b0;
		end
		half();
		o_scl = 1'b1;
		half();
		o_scl = 1'b0;
		i2c_low = 1'b1;
		half();
		o_scl = 1'b1;
		half();
		i2c_low = 1'b0;
		half();
	endtask
endmodule // host_serial_model
`default_nettype wire

// ==== bench/test_ir_presence_sensor_readout.sv ====
// Self-checking bench of the IR presence sensor readout
`default_nettype none
module test_ir_presence_sensor_readout;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int BT = 10;
	logic                        i_core_clk = 1'b0;
	logic                        i_reset_n = 1'b0;
	logic [3:0]                  rate = 4'h0;
	logic                        one_shot = 1'b0;
	ir_readout_pkg::detect_cfg_t cfg = 3'h0;
	ir_readout_pkg::adc_result_t adc = '0;
	logic signed [15:0]          aobj = 16'h1000;
	logic signed [15:0]          aamb = 16'h0a8c;
	logic                        acq, pdn, intp, sel, scl, sda, dpin, doe_n, ack;
	ir_readout_pkg::flags_t      flags;
	logic [7:0]                  byt;
	logic [31:0]                 q[$];
	int num_errors = 0, checks_done = 0, cyc = 0, starts = 0, last = 0, gap = 0, os_cyc = 0, adc_wait = 0, n;
	int codes[9] = '{1, 2, 3, 4, 5, 6, 7, 8, 15};
	int per[9] = '{480, 240, 120, 60, 30, 15, 8, 4, 4};
	always #2.5 i_core_clk = ~i_core_clk;
	ir_presence_sensor_readout #(.BASE_TICK(BT)) u_ir_presence_sensor_readout (
		.i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_output_rate_code(rate), .i_one_shot(one_shot),
		.i_detect_cfg(cfg), .i_motion_thr(16'sh1000), .i_presence_thr(16'sh0800), .i_overtemp_thr(16'sh2000),
		.i_adc(adc), .o_acq_start(acq), .o_power_down(pdn), .o_flags(flags), .o_int_pin(intp),
		.i_if_select_pin(sel), .i_serial_clock_pin(scl), .i_serial_data_io_pin(sda),
		.o_serial_data_io_pin(dpin), .o_serial_data_io_oe_n(doe_n));
	host_serial_model u_host_serial_model (.i_core_clk(i_core_clk), .i_dev_pin(dpin), .i_dev_oe_n(doe_n),
		.o_select(sel), .o_scl(scl), .o_sda(sda));
	// ================================================================
	// Start monitor and converter stand-in
	// Looks just past the edge so that registered outputs have settled
	always @(posedge i_core_clk) begin
		#1;
		cyc++;
		if (acq) begin
			starts++;
			gap = cyc - last;
			last = cyc;
		end
	end
	always @(negedge i_core_clk) begin
		adc <= '{(adc_wait == 1), aobj, aamb};
		adc_wait <= acq ? 4 : (adc_wait > 0 ? adc_wait - 1 : 0);
	end
	function automatic logic [31:0] word_of(input logic signed [15:0] o, input logic signed [15:0] a);
		logic signed [31:0] c;
		c = 32'(o) - (((32'(a) - ir_readout_pkg::AMB_REF) * ir_readout_pkg::COMP_GAIN) >>> 4);
		return {c[15:0], a};
	endfunction
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h, seen %h", name, exp, got);
		end
	endtask
	task automatic complete_run();
		if (num_errors == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic wait_start(input int want, input int lim);
		for (int t = 0; starts < want && t < lim; t++) @(negedge i_core_clk);
		chk("start count", want, starts);
	endtask
	task automatic shot();
		@(negedge i_core_clk);
		one_shot = 1'b1;
		os_cyc = cyc;
		@(negedge i_core_clk);
		one_shot = 1'b0;
		wait_start(starts + 1, 20);
		chk("start latency", 2, last - os_cyc);
		repeat (8) @(negedge i_core_clk);
	endtask
	// ================================================================
	// Tests
	initial begin
		repeat (4) @(negedge i_core_clk);
		chk("power down in reset", 1, pdn);
		chk("data enable in reset", 1, doe_n);
		i_reset_n = 1'b1;
		repeat (300) @(negedge i_core_clk);
		chk("power down", 1, pdn);
		chk("starts while off", 0, starts);
		shot();
		u_host_serial_model.i2c_read(ack, byt);
		chk("i2c ack", 0, ack);
		chk("i2c object high", word_of(aobj, aamb) >> 24, byt);
		shot();
		u_host_serial_model.spi_read(2, q);
		chk("spi word", word_of(aobj, aamb), q[0]);
		chk("spi empty", 0, q[1]);
		cfg = 3'h7;
		shot();
		chk("flags still", 4'h6, flags);
		aobj = 16'h3000;
		shot();
		chk("flags moving", 4'hd, flags);
		chk("int pin", 1, intp);
		cfg = 3'h0;
		repeat (3) @(negedge i_core_clk);
		chk("flags off", 0, flags);
		chk("int pin off", 0, intp);
		u_host_serial_model.spi_read(2, q);
		chk("moving word", word_of(aobj, aamb), q[1]);
		// Fill the buffer at the fastest rate until starts are refused
		n = starts;
		rate = 4'h8;
		repeat (2000) @(negedge i_core_clk);
		chk("power up", 0, pdn);
		chk("starts until full", 16, starts - n);
		rate = 4'h0;
		u_host_serial_model.spi_read(17, q);
		for (int i = 0; i < 16; i++) chk("buffer word", word_of(aobj, aamb), q[i]);
		chk("buffer drained", 0, q[16]);
		for (int k = 0; k < 9; k++) begin
			rate = 4'(codes[k]);
			wait_start(starts + 2, 2 * per[k] * (BT + 1) + 60);
			checks_done++;
			if (gap < per[k] * BT || gap > per[k] * (BT + 1) + 4) begin
				num_errors++;
				$display("unexpected rate gap: expected %0d, seen %0d", per[k] * BT, gap);
			end
			rate = 4'h0;
			repeat (20) @(negedge i_core_clk);
			u_host_serial_model.spi_read(3, q);
		end
		// Ambient at the reference point leaves the object word untouched
		aamb = 16'h09c4;
		shot();
		u_host_serial_model.spi_read(1, q);
		chk("neutral word", 32'h300009c4, q[0]);
		complete_run();
	end
	// Generous bound: the tests need about 200 us
	initial begin
		#400000;
		num_errors++;
		complete_run();
	end
endmodule // test_ir_presence_sensor_readout
`default_nettype wire
